/* File: src/adc_cmd_pkg.sv */
// Constants shared by the serial command and readout logic
package adc_cmd_pkg;
  // Serial opcodes (bit 0 ignored for control group)
  localparam logic [6:0] OP_WAKE     = 7'h00;
  localparam logic [6:0] OP_STANDBY  = 7'h01;
  localparam logic [6:0] OP_SYNC     = 7'h02;
  localparam logic [6:0] OP_RESET    = 7'h03;
  localparam logic [7:0] OP_CONTINUOUS_READ_OPCODE   = 8'h10;
  localparam logic [7:0] OP_STOP_CONTINUOUS_OPCODE   = 8'h11;
  localparam logic [7:0] OP_RDATA    = 8'h12;
  localparam logic [2:0] OP_REGISTER_READ_OPCODE_HI  = 3'h1;
  localparam logic [2:0] OP_REGISTER_WRITE_OPCODE_HI  = 3'h2;
  localparam logic [7:0] OP_OFS_CAL  = 8'h60;
  localparam logic [7:0] OP_GAIN_CAL = 8'h61;
  // Register map of the converter
  localparam int         NUM_REGS    = 11;
  localparam logic [4:0] LAST_REG    = 5'h0a;
  localparam logic [3:0] CFG0_IDX    = 4'h1;
  localparam logic [4:0] OFC_BASE    = 5'h05;
  localparam logic [4:0] FSC_BASE    = 5'h08;
  localparam logic [7:0] REG_RST [0:10] = '{8'h00, 8'h52, 8'h08, 8'h32, 8'h03,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};
  localparam logic [1:0] FILT_BYPASS = 2'h0;
  localparam logic [1:0] FILT_SINC   = 2'h1;
  // Result codes
  localparam logic [31:0] CLIP_POS   = 32'h7fffffff;
  localparam logic [31:0] CLIP_NEG   = 32'h80000000;
  // Counts in master-clock cycles or result periods
  localparam logic [2:0] PULSE_CYC   = 3'h4;
  localparam logic [6:0] TIMEOUT_PER = 7'h40;
  localparam logic [5:0] LOST_READS  = 6'h3f;
  localparam logic [2:0] MCLK_WRAP   = 3'h3;
  localparam logic [2:0] MCLK_SYNC   = 3'h5;
  // Bus register offsets
  localparam logic [3:0] OFF_STATUS  = 4'h0;
  localparam logic [3:0] OFF_CONTROL = 4'h4;
  localparam logic [3:0] OFF_RESULT  = 4'h8;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Command decoder states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_RD_CNT = 3'b001, ST_RD_DATA = 3'b010,
    ST_WR_CNT = 3'b011, ST_WR_DATA = 3'b100
  } state_type;
endpackage : adc_cmd_pkg

/* File: src/adc_serial_command_readout.sv */
// Serial command interpreter and result readout of a delta-sigma converter
// Functional notes
// - Result is 32 bits, LSB repeats sign
// - Clip codes: positive LSB set, negative cleared
// - Sinc-only halves scale, never clips
// - Continuous mode default; MSB out at ready fall
// - First SCLK fall raises ready; then zeros
// - Stop-continuous blocks ready, conversions continue
// - Read-data opcode; ready falls when data arrive
// - Wake-up leaves standby, else no effect
// - Filter select 00: modulator pins drive, clk/4
// - Sync restarts modulator clock, rise five later
// - Control opcodes decoded ignoring bit 0
// - Opcodes 10h, 11h, 12h recognised
// - Calibration opcodes update calibration registers
// - Register read: address, count; data from 16th fall
// - Register write: address, count, data bytes
// - Sync opcode restarts conversion process
// - Reset opcode loads defaults, continuous on
// - Standby keeps registers and serial port alive
// - Capture on SCLK rise, drive on fall
// - SCLK low 64 periods resets serial port
// - Unread result: ready pulses high four clocks
// - Register write restarts, 63 readings lost
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module adc_serial_command_readout #(
  parameter logic [7:0] ID_VALUE = 8'h00, // Arbitrary identity value
  parameter int         AW       = 4
) (
  input  wire logic          I_SYS_CLK,
  input  wire logic          I_RST,
  input  wire logic          I_SCLK,
  input  wire logic          I_DIN,
  input  wire logic          I_SYNC,
  output logic               O_DOUT,
  output logic               O_RESULT_READY_N,
  input  wire logic [30:0]   I_SAMPLE,
  input  wire logic          I_SAMPLE_VALID,
  input  wire logic          I_CLIP_POS,
  input  wire logic          I_CLIP_NEG,
  input  wire logic [1:0]    I_MOD_BITS,
  input  wire logic          I_CAL_DONE,
  input  wire logic [23:0]   I_CAL_VALUE,
  output logic               O_CAL_START,
  output logic               O_CAL_GAIN,
  output logic               O_RESTART,
  output logic               O_STANDBY,
  output logic [1:0]         O_FILTER_SELECT,
  output logic               O_MODULATOR_BIT_A,
  output logic               O_MODULATOR_BIT_A_OE,
  output logic               O_MODULATOR_BIT_B,
  output logic               O_MODULATOR_BIT_B_OE,
  output logic               O_MOD_CLK,
  output logic               O_MOD_CLK_OE,
  input  wire logic [AW-1:0] I_AWADDR,
  input  wire logic          I_AWVALID,
  output logic               O_AWREADY,
  input  wire logic [31:0]   I_WDATA,
  input  wire logic [3:0]    I_WSTRB,
  input  wire logic          I_WVALID,
  output logic               O_WREADY,
  output logic [1:0]         O_BRESP,
  output logic               O_BVALID,
  input  wire logic          I_BREADY,
  input  wire logic [AW-1:0] I_ARADDR,
  input  wire logic          I_ARVALID,
  output logic               O_ARREADY,
  output logic [31:0]        O_RDATA,
  output logic [1:0]         O_RRESP,
  output logic               O_RVALID,
  input  wire logic          I_RREADY
);
  // Pin synchronisers; the third SCLK stage is only for edge finding
  logic [2:0] sclk_s;
  logic [1:0] din_s;
  logic [2:0] sync_s;
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      sclk_s <= 3'h0;
      din_s  <= 2'h0;
      sync_s <= 3'h7; // Sync idles high; no false rise after reset
    end else begin
      sclk_s <= {sclk_s[1:0], I_SCLK};
      din_s  <= {din_s[0], I_DIN};
      sync_s <= {sync_s[1:0], I_SYNC};
    end
  end
  logic sclk_rise, sclk_fall, sync_rise;
  assign sclk_rise = sclk_s[1] & ~sclk_s[2];
  assign sclk_fall = ~sclk_s[1] & sclk_s[2];
  assign sync_rise = sync_s[1] & ~sync_s[2];

  logic [7:0] regs_r [0:10];
  logic [7:0] regs_nxt [0:10];
  logic bypass;
  assign bypass = regs_r[adc_cmd_pkg::CFG0_IDX][1:0] == adc_cmd_pkg::FILT_BYPASS;

  // Modulator clock divider, phase reset by sync
  logic [2:0] mcnt_r, mcnt_nxt;
  logic       mclk_r, mclk_nxt;
  logic [1:0] mbits_r, mbits_nxt;
  always_comb begin
    if (bypass && sync_rise) begin
      mcnt_nxt = adc_cmd_pkg::MCLK_SYNC;
    end else if (mcnt_r == adc_cmd_pkg::MCLK_WRAP) begin
      mcnt_nxt = 3'h0;
    end else begin
      mcnt_nxt = mcnt_r + 3'h1;
    end
    mclk_nxt  = mcnt_nxt[2:1] == 2'h1;
    mbits_nxt = I_MOD_BITS;
  end
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      mcnt_r  <= 3'h0;
      mclk_r  <= 1'b0;
      mbits_r <= 2'h0;
    end else begin
      mcnt_r  <= mcnt_nxt;
      mclk_r  <= mclk_nxt;
      mbits_r <= mbits_nxt;
    end
  end

  // Result formatting: sign copy in LSB, clip codes, sinc half scale
  logic [31:0] fmt;
  logic        sinc;
  assign sinc = regs_r[adc_cmd_pkg::CFG0_IDX][1:0] == adc_cmd_pkg::FILT_SINC;
  always_comb begin
    if (sinc) begin
      fmt = {I_SAMPLE[30], I_SAMPLE};
    end else if (I_CLIP_POS) begin
      fmt = adc_cmd_pkg::CLIP_POS;
    end else if (I_CLIP_NEG) begin
      fmt = adc_cmd_pkg::CLIP_NEG;
    end else begin
      fmt = {I_SAMPLE, I_SAMPLE[30]};
    end
  end

  // Serial command and readout state
  adc_cmd_pkg::state_type st_r, st_nxt;
  logic [2:0]  bit_r, bit_nxt, pls_r, pls_nxt;
  logic [6:0]  rx_r, rx_nxt, to_r, to_nxt;
  logic [4:0]  addr_r, addr_nxt, left_r, left_nxt;
  logic [31:0] tx_r, tx_nxt, word_r, word_nxt;
  logic [5:0]  disc_r, disc_nxt;
  logic cont_r, cont_nxt, stby_r, stby_nxt, pend_r, pend_nxt, rdy_r, rdy_nxt;
  logic ld_r, ld_nxt, cal_r, cal_nxt, calg_r, calg_nxt, rst_r, rst_nxt;
  logic ctl_hold_r;
  logic [7:0]  b, rd_byte;
  logic        accept, to_hit;
  assign b       = {rx_r, din_s[1]};
  assign accept  = I_SAMPLE_VALID && disc_r == 6'h0 && !stby_r;
  assign to_hit  = to_r == adc_cmd_pkg::TIMEOUT_PER;
  assign rd_byte = addr_r <= adc_cmd_pkg::LAST_REG ? regs_r[addr_r[3:0]] : 8'h00;
  always_comb begin
    st_nxt = st_r;  bit_nxt = bit_r;  rx_nxt = rx_r;  addr_nxt = addr_r;
    left_nxt = left_r;  regs_nxt = regs_r;  cont_nxt = cont_r;
    stby_nxt = stby_r;  pend_nxt = pend_r;  pls_nxt = pls_r;  rdy_nxt = rdy_r;
    tx_nxt = tx_r;  word_nxt = word_r;  disc_nxt = disc_r;  ld_nxt = ld_r;
    cal_nxt = 1'b0;  calg_nxt = calg_r;  rst_nxt = 1'b0;
    // Idle SCLK counted in result periods
    if (sclk_rise || sclk_fall) begin
      to_nxt = 7'h0;
    end else if (I_SAMPLE_VALID && !to_hit) begin
      to_nxt = to_r + 7'h1;
    end else begin
      to_nxt = to_r;
    end
    // New result; readings after a restart are dropped
    if (accept) begin
      word_nxt = fmt;
      if (cont_r || pend_r) begin
        pls_nxt  = adc_cmd_pkg::PULSE_CYC;
        rdy_nxt  = 1'b1;
        pend_nxt = 1'b0;
      end
    end else if (I_SAMPLE_VALID && disc_r != 6'h0) begin
      disc_nxt = disc_r - 6'h1;
    end
    // Output changes on falling SCLK
    if (sclk_fall) begin
      rdy_nxt = 1'b1;
      tx_nxt  = ld_r ? {rd_byte, 24'h0} : {tx_r[30:0], 1'b0};
      ld_nxt  = 1'b0;
    end
    // End of high pulse: ready falls with MSB already on the pin
    if (pls_r != 3'h0) begin
      pls_nxt = pls_r - 3'h1;
      if (pls_r == 3'h1) begin
        rdy_nxt = 1'b0;
        tx_nxt  = word_r;
      end
    end
    // Input captured on rising SCLK
    if (sclk_rise) begin
      rx_nxt  = b[6:0];
      bit_nxt = bit_r + 3'h1;
      if (bit_r == 3'h7) begin
        unique case (st_r)
          adc_cmd_pkg::ST_IDLE: begin
            if (b[7:1] == adc_cmd_pkg::OP_WAKE) begin
              stby_nxt = 1'b0;
            end else if (b[7:1] == adc_cmd_pkg::OP_STANDBY) begin
              stby_nxt = 1'b1;
            end else if (b[7:1] == adc_cmd_pkg::OP_SYNC) begin
              rst_nxt  = 1'b1;
              disc_nxt = adc_cmd_pkg::LOST_READS;
            end else if (b[7:1] == adc_cmd_pkg::OP_RESET) begin
              regs_nxt = adc_cmd_pkg::REG_RST;
              cont_nxt = 1'b1;
              rst_nxt  = 1'b1;
              disc_nxt = adc_cmd_pkg::LOST_READS;
            end else if (b == adc_cmd_pkg::OP_CONTINUOUS_READ_OPCODE) begin
              cont_nxt = 1'b1;
            end else if (b == adc_cmd_pkg::OP_STOP_CONTINUOUS_OPCODE) begin
              cont_nxt = 1'b0;
            end else if (b == adc_cmd_pkg::OP_RDATA) begin
              pend_nxt = 1'b1;
            end else if (b[7:5] == adc_cmd_pkg::OP_REGISTER_READ_OPCODE_HI) begin
              addr_nxt = b[4:0];
              st_nxt   = adc_cmd_pkg::ST_RD_CNT;
            end else if (b[7:5] == adc_cmd_pkg::OP_REGISTER_WRITE_OPCODE_HI) begin
              addr_nxt = b[4:0];
              st_nxt   = adc_cmd_pkg::ST_WR_CNT;
            end else if (b == adc_cmd_pkg::OP_OFS_CAL || b == adc_cmd_pkg::OP_GAIN_CAL) begin
              cal_nxt  = 1'b1;
              calg_nxt = b[0];
            end
            // Anything else falls through unused
          end
          adc_cmd_pkg::ST_RD_CNT: begin
            left_nxt = b[4:0];
            st_nxt   = adc_cmd_pkg::ST_RD_DATA;
            ld_nxt   = 1'b1;
          end
          adc_cmd_pkg::ST_RD_DATA: begin
            if (left_r == 5'h0) begin
              st_nxt = adc_cmd_pkg::ST_IDLE;
            end else begin
              left_nxt = left_r - 5'h1;
              addr_nxt = addr_r + 5'h1;
              ld_nxt   = 1'b1;
            end
          end
          adc_cmd_pkg::ST_WR_CNT: begin
            left_nxt = b[4:0];
            st_nxt   = adc_cmd_pkg::ST_WR_DATA;
          end
          adc_cmd_pkg::ST_WR_DATA: begin
            // Identity byte is read-only; unmapped addresses are dropped
            if (addr_r != 5'h0 && addr_r <= adc_cmd_pkg::LAST_REG) begin
              regs_nxt[addr_r[3:0]] = b;
            end
            rst_nxt  = 1'b1;
            disc_nxt = adc_cmd_pkg::LOST_READS;
            if (left_r == 5'h0) begin
              st_nxt = adc_cmd_pkg::ST_IDLE;
            end else begin
              left_nxt = left_r - 5'h1;
              addr_nxt = addr_r + 5'h1;
            end
          end
          default: st_nxt = adc_cmd_pkg::ST_IDLE;
        endcase
      end
    end
    // Calibration engine writes its three-byte answer
    if (I_CAL_DONE) begin
      for (int i = 0; i < 3; i++) begin
        regs_nxt[(calg_r ? 4'h8 : 4'h5) + 4'(i)] = I_CAL_VALUE[8*i +: 8];
      end
    end
    regs_nxt[0] = ID_VALUE;
    // Stalled SCLK or software hold recovers the port; the next edge counts
    if ((to_hit && !sclk_rise && !sclk_fall) || ctl_hold_r) begin
      st_nxt  = adc_cmd_pkg::ST_IDLE;
      bit_nxt = 3'h0;
      ld_nxt  = 1'b0;
    end
  end
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_r <= adc_cmd_pkg::ST_IDLE;
      bit_r <= 3'h0;  rx_r <= 7'h0;  to_r <= 7'h0;  addr_r <= 5'h0;
      left_r <= 5'h0;  regs_r <= adc_cmd_pkg::REG_RST;  cont_r <= 1'b1;
      stby_r <= 1'b0;  pend_r <= 1'b0;  pls_r <= 3'h0;  rdy_r <= 1'b1;
      tx_r <= 32'h0;  word_r <= 32'h0;  disc_r <= 6'h0;  ld_r <= 1'b0;
      cal_r <= 1'b0;  calg_r <= 1'b0;  rst_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;  rx_r <= rx_nxt;  to_r <= to_nxt;  addr_r <= addr_nxt;
      left_r <= left_nxt;  regs_r <= regs_nxt;  cont_r <= cont_nxt;
      stby_r <= stby_nxt;  pend_r <= pend_nxt;  pls_r <= pls_nxt;  rdy_r <= rdy_nxt;
      tx_r <= tx_nxt;  word_r <= word_nxt;  disc_r <= disc_nxt;  ld_r <= ld_nxt;
      cal_r <= cal_nxt;  calg_r <= calg_nxt;  rst_r <= rst_nxt;
    end
  end

  // Bus slave; one write and one read at a time
  logic          awg_r, awg_nxt, wg_r, wg_nxt, bv_r, bv_nxt, rv_r, rv_nxt;
  logic          ctl_nxt;
  logic [AW-1:0] awa_r, awa_nxt;
  logic [31:0]   wd_r, wd_nxt, rd_r, rd_nxt;
  logic [1:0]    br_r, br_nxt, rr_r, rr_nxt;
  logic [3:0]    ws_r, ws_nxt;
  assign O_AWREADY = !awg_r && !bv_r;
  assign O_WREADY  = !wg_r && !bv_r;
  assign O_ARREADY = !rv_r;
  always_comb begin
    awg_nxt = awg_r;  wg_nxt = wg_r;  bv_nxt = bv_r;  rv_nxt = rv_r;
    awa_nxt = awa_r;  wd_nxt = wd_r;  ws_nxt = ws_r;  br_nxt = br_r;
    rd_nxt = rd_r;  rr_nxt = rr_r;  ctl_nxt = ctl_hold_r;
    if (I_AWVALID && O_AWREADY) begin
      awg_nxt = 1'b1;
      awa_nxt = I_AWADDR;
    end
    if (I_WVALID && O_WREADY) begin
      wg_nxt = 1'b1;
      wd_nxt = I_WDATA;
      ws_nxt = I_WSTRB;
    end
    if (awg_r && wg_r) begin
      awg_nxt = 1'b0;
      wg_nxt  = 1'b0;
      bv_nxt  = 1'b1;
      br_nxt  = awa_r[3:0] == adc_cmd_pkg::OFF_CONTROL ? adc_cmd_pkg::RESP_OKAY
                                                      : adc_cmd_pkg::RESP_SLVERR;
      if (awa_r[3:0] == adc_cmd_pkg::OFF_CONTROL && ws_r[0]) begin
        ctl_nxt = wd_r[0];
      end
    end else if (bv_r && I_BREADY) begin
      bv_nxt = 1'b0;
    end
    if (I_ARVALID && O_ARREADY) begin
      rv_nxt = 1'b1;
      rr_nxt = adc_cmd_pkg::RESP_OKAY;
      unique case (I_ARADDR[3:0])
        adc_cmd_pkg::OFF_STATUS:  rd_nxt = {22'h0, regs_r[1][1:0], st_r, pend_r,
                                             bypass, stby_r, cont_r, rdy_r};
        adc_cmd_pkg::OFF_CONTROL: rd_nxt = {31'h0, ctl_hold_r};
        adc_cmd_pkg::OFF_RESULT:  rd_nxt = word_r;
        default: begin
          rd_nxt = 32'h0;
          rr_nxt = adc_cmd_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rv_r && I_RREADY) begin
      rv_nxt = 1'b0;
    end
  end
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      awg_r <= 1'b0;  wg_r <= 1'b0;  bv_r <= 1'b0;  rv_r <= 1'b0;
      awa_r <= '0;  wd_r <= 32'h0;  ws_r <= 4'h0;  br_r <= 2'h0;
      rd_r <= 32'h0;  rr_r <= 2'h0;  ctl_hold_r <= 1'b0;
    end else begin
      awg_r <= awg_nxt;  wg_r <= wg_nxt;  bv_r <= bv_nxt;  rv_r <= rv_nxt;
      awa_r <= awa_nxt;  wd_r <= wd_nxt;  ws_r <= ws_nxt;  br_r <= br_nxt;
      rd_r <= rd_nxt;  rr_r <= rr_nxt;  ctl_hold_r <= ctl_nxt;
    end
  end

  // Outputs from flip-flops; the three enables are decoded from the filter select bits
  assign O_DOUT               = tx_r[31];
  assign O_RESULT_READY_N     = rdy_r;
  assign O_CAL_START          = cal_r;
  assign O_CAL_GAIN           = calg_r;
  assign O_RESTART            = rst_r;
  assign O_STANDBY            = stby_r;
  assign O_FILTER_SELECT      = regs_r[adc_cmd_pkg::CFG0_IDX][1:0];
  assign O_MODULATOR_BIT_A    = mbits_r[0];
  assign O_MODULATOR_BIT_B    = mbits_r[1];
  assign O_MOD_CLK            = mclk_r;
  assign O_MODULATOR_BIT_A_OE = bypass;
  assign O_MODULATOR_BIT_B_OE = bypass;
  assign O_MOD_CLK_OE         = bypass;
  assign O_BVALID = bv_r;
  assign O_BRESP  = br_r;
  assign O_RVALID = rv_r;
  assign O_RDATA  = rd_r;
  assign O_RRESP  = rr_r;

  // Checks
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  a_lsb_sign: assert property (accept && !sinc && !I_CLIP_POS && !I_CLIP_NEG
    |=> word_r[0] == word_r[31])
    else $error("result LSB differs from sign");
  a_clip_pos: assert property (accept && !sinc && I_CLIP_POS |=> word_r == 32'h7fffffff)
    else $error("positive clip code wrong");
  a_ready_pulse: assert property (accept && cont_r && !sclk_rise && !sclk_fall
    |=> rdy_r[*4] ##1 !rdy_r)
    else $error("ready pulse not four clocks");
  a_msb_first: assert property ($fell(rdy_r) |-> O_DOUT == word_r[31])
    else $error("MSB not on pin at ready fall");
  a_fall_raise: assert property (sclk_fall |=> rdy_r)
    else $error("ready not raised by SCLK fall");
  a_blocked: assert property (!cont_r && !pend_r && pls_r == 3'h0 && rdy_r |=> rdy_r)
    else $error("ready fell while blocked");
  a_mclk_sync: assert property (bypass && sync_rise |-> ##1 !O_MOD_CLK[*5] ##1 O_MOD_CLK)
    else $error("modulator clock sync phase wrong");
  a_mclk_div: assert property ($rose(O_MOD_CLK) && !sync_rise ##1 !sync_rise ##1 !sync_rise
    ##1 !sync_rise |=> $rose(O_MOD_CLK))
    else $error("modulator clock not divide by four");
  a_timeout: assert property (to_hit && !sclk_rise && !sclk_fall
    |=> st_r == adc_cmd_pkg::ST_IDLE && bit_r == 3'h0)
    else $error("serial port not reset on timeout");
  c_cont_read: cover property ($fell(rdy_r) ##[1:40] sclk_fall);
  c_reg_read: cover property (st_r == adc_cmd_pkg::ST_RD_DATA && ld_r && sclk_fall);
  c_reg_write: cover property (st_r == adc_cmd_pkg::ST_WR_DATA && sclk_rise && bit_r == 3'h7);
endmodule : adc_serial_command_readout

/* File: sim/serial_host.sv */
// Host controller model driving the serial command link
`timescale 1ns/1ps
module serial_host (
  input  wire logic I_SYS_CLK,
  input  wire logic i_dout,
  output logic      o_sclk,
  output logic      o_din
);
  localparam int HALF = 4;  // Clocks per SCLK phase, margin over three
  localparam int GAP  = 30; // Clocks after each byte, margin over the minimum
  // Link idles with SCLK low so the timeout logic sees no edges
  initial begin
    o_sclk = 1'b0;
    o_din  = 1'b0;
  end
  // One SCLK pulse: DIN set while low, DOUT taken at the rise
  task automatic pulse(input logic b, output logic q);
    o_din <= b;
    repeat (HALF) @(posedge I_SYS_CLK);
    o_sclk <= 1'b1;
    q = i_dout;
    repeat (HALF) @(posedge I_SYS_CLK);
    o_sclk <= 1'b0;
  endtask : pulse
  // Shift n bits MSB first, then keep the byte gap
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    logic q;
    rx = '0;
    for (int i = n - 1; i >= 0; i--) begin
      pulse(tx[i], q);
      rx[i] = q;
    end
    @(posedge I_SYS_CLK);
    o_din <= 1'b0; // Low between bytes, as continuous reads expect
    repeat (GAP) @(posedge I_SYS_CLK);
  endtask : xfer
endmodule : serial_host

/* File: sim/adc_serial_command_readout_tb.sv */
// Self-checking bench for the serial command and readout block
`timescale 1ns/1ps
module adc_serial_command_readout_tb;
  logic        I_SYS_CLK, I_RST, I_SCLK, I_DIN, I_SYNC, O_DOUT, O_RESULT_READY_N;
  logic [30:0] I_SAMPLE;
  logic        I_SAMPLE_VALID, I_CLIP_POS, I_CLIP_NEG, I_CAL_DONE, O_CAL_START, O_CAL_GAIN;
  logic        O_RESTART, O_STANDBY, O_MODULATOR_BIT_A, O_MODULATOR_BIT_A_OE, mclk_q;
  logic        O_MODULATOR_BIT_B, O_MODULATOR_BIT_B_OE, O_MOD_CLK, O_MOD_CLK_OE;
  logic [1:0]  I_MOD_BITS, O_FILTER_SELECT, O_BRESP, O_RRESP;
  logic [23:0] I_CAL_VALUE;
  logic [3:0]  I_AWADDR, I_ARADDR, I_WSTRB;
  logic [31:0] I_WDATA, O_RDATA, rx, ex;
  logic        I_AWVALID, O_AWREADY, I_WVALID, O_WREADY, O_BVALID, I_BREADY;
  logic        I_ARVALID, O_ARREADY, O_RVALID, I_RREADY;
  int          failures = 0, cmp_count = 0, cal_cnt = 0, rs_cnt = 0, mck_cnt = 0, c0;
  logic [30:0] sv [4] = '{31'h12345678, 31'h40000001, 31'h3fffffff, 31'h7ffffffe};
  logic [23:0] cv [2] = '{24'h123456, 24'habcdef};
  logic [7:0]  op [6] = '{8'h02, 8'h00, 8'h03, 8'h01, 8'h00, 8'h7f};
  logic [5:0]  sb     = 6'b000101; // Standby level expected after each op

  adc_serial_command_readout dut (
    .I_SYS_CLK, .I_RST, .I_SCLK, .I_DIN, .I_SYNC, .O_DOUT, .O_RESULT_READY_N, .I_SAMPLE,
    .I_SAMPLE_VALID, .I_CLIP_POS, .I_CLIP_NEG, .I_MOD_BITS, .I_CAL_DONE, .I_CAL_VALUE,
    .O_CAL_START, .O_CAL_GAIN, .O_RESTART, .O_STANDBY, .O_FILTER_SELECT,
    .O_MODULATOR_BIT_A, .O_MODULATOR_BIT_A_OE, .O_MODULATOR_BIT_B, .O_MODULATOR_BIT_B_OE,
    .O_MOD_CLK, .O_MOD_CLK_OE, .I_AWADDR, .I_AWVALID, .O_AWREADY, .I_WDATA, .I_WSTRB,
    .I_WVALID, .O_WREADY, .O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID,
    .O_ARREADY, .O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY
  );
  serial_host host (.I_SYS_CLK, .i_dout(O_DOUT), .o_sclk(I_SCLK), .o_din(I_DIN));

  // 50 MHz master clock
  initial begin
    I_SYS_CLK = 1'b0;
    forever #10 I_SYS_CLK = ~I_SYS_CLK;
  end
  // Pulses are one cycle wide, so count them at every edge
  always @(posedge I_SYS_CLK) begin
    if (O_CAL_START === 1'b1) cal_cnt++;
    if (O_RESTART === 1'b1) rs_cnt++;
    if (O_MOD_CLK === 1'b1 && mclk_q === 1'b0) mck_cnt++;
    mclk_q = O_MOD_CLK;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic final_report();
    $display("Compares %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : final_report
  // Bus write: address and data offered together, each dropped once taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge I_SYS_CLK);
    {I_AWADDR, I_WDATA, I_AWVALID, I_WVALID, I_BREADY} <= {a, d, 3'b111};
    do begin
      @(negedge I_SYS_CLK);
      ta |= (O_AWREADY === 1'b1);
      tw |= (O_WREADY === 1'b1);
      @(posedge I_SYS_CLK);
      if (ta) I_AWVALID <= 1'b0;
      if (tw) I_WVALID <= 1'b0;
    end while (!(ta && tw));
    do @(negedge I_SYS_CLK); while (O_BVALID !== 1'b1);
    chk("bresp", er, O_BRESP);
    @(posedge I_SYS_CLK);
    I_BREADY <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] e, m, input logic [1:0] er);
    @(posedge I_SYS_CLK);
    {I_ARADDR, I_ARVALID, I_RREADY} <= {a, 2'b11};
    do @(negedge I_SYS_CLK); while (O_ARREADY !== 1'b1);
    @(posedge I_SYS_CLK);
    I_ARVALID <= 1'b0;
    do @(negedge I_SYS_CLK); while (O_RVALID !== 1'b1);
    chk("rdata", e, O_RDATA & m);
    chk("rresp", er, O_RRESP);
    @(posedge I_SYS_CLK);
    I_RREADY <= 1'b0;
  endtask : axi_rd
  task automatic cmd(input logic [7:0] b);
    host.xfer(8, {24'h0, b}, rx);
  endtask : cmd
  // One result, valid for a single master clock; does not wait for any readout
  task automatic samp(input logic [30:0] s, input logic p, input logic n);
    @(posedge I_SYS_CLK);
    {I_SAMPLE, I_CLIP_POS, I_CLIP_NEG, I_SAMPLE_VALID} <= {s, p, n, 1'b1};
    @(posedge I_SYS_CLK);
    I_SAMPLE_VALID <= 1'b0;
  endtask : samp
  task automatic read_word(input logic [31:0] e, input int n);
    while (O_RESULT_READY_N !== 1'b0) @(posedge I_SYS_CLK);
    @(negedge I_SYS_CLK);
    chk("msb", e[31], O_DOUT);
    host.xfer(n, 32'h0, rx);
    chk("word", e >> (32 - n), rx);
    chk("ready_back", 1, O_RESULT_READY_N);
  endtask : read_word
  task automatic rd_reg(input logic [4:0] a, input logic [7:0] e);
    cmd({3'b001, a});
    cmd(8'h00);
    host.xfer(8, 32'h0, rx);
    chk("reg", e, rx);
  endtask : rd_reg
  // Hang guard, well past the expected run length
  initial begin
    #1ms;
    failures++;
    final_report();
  end

  // Main sequence
  initial begin
    {I_RST, I_SYNC, I_MOD_BITS, I_WSTRB} = {2'b11, 2'h1, 4'hf};
    {I_SAMPLE, I_SAMPLE_VALID, I_CLIP_POS, I_CLIP_NEG, I_CAL_DONE, I_CAL_VALUE} = '0;
    {I_AWADDR, I_ARADDR, I_WDATA, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = '0;
    repeat (3) @(posedge I_SYS_CLK);
    I_RST <= 1'b0;
    @(negedge I_SYS_CLK);
    chk("ready_rst", 1, O_RESULT_READY_N);
    chk("oe_rst", 0, {O_MOD_CLK_OE, O_MODULATOR_BIT_B_OE, O_MODULATOR_BIT_A_OE, O_DOUT});
    chk("filt_rst", 2'h2, O_FILTER_SELECT);
    axi_rd(4'h0, 32'h3, 32'h3, adc_cmd_pkg::RESP_OKAY);
    axi_wr(4'h4, 32'h1, adc_cmd_pkg::RESP_OKAY);
    axi_rd(4'h4, 32'h1, 32'h1, adc_cmd_pkg::RESP_OKAY);
    axi_wr(4'h4, 32'h0, adc_cmd_pkg::RESP_OKAY);
    axi_wr(4'h8, 32'h5, adc_cmd_pkg::RESP_SLVERR);
    axi_rd(4'hc, 32'h0, 32'hffffffff, adc_cmd_pkg::RESP_SLVERR);
    // Continuous reads: plain, negative, both clips; second one cut at 24
    for (int i = 0; i < 4; i++) begin
      samp(sv[i], i == 2, i == 3);
      ex = (i == 2) ? 32'h7fffffff : (i == 3) ? 32'h80000000 : {sv[i], sv[i][30]};
      read_word(ex, (i == 1) ? 24 : 32);
    end
    host.xfer(8, 32'h0, rx);
    chk("tail", 0, rx);
    cmd(8'h11);
    axi_rd(4'h0, 32'h0, 32'h2, adc_cmd_pkg::RESP_OKAY);
    samp(sv[0], 1'b0, 1'b0);
    repeat (8) @(posedge I_SYS_CLK);
    chk("ready_blocked", 1, O_RESULT_READY_N);
    cmd(8'h12);
    samp(sv[1], 1'b0, 1'b0);
    read_word({sv[1], sv[1][30]}, 32);
    rd_reg(5'h01, 8'h52);
    // Write filter select 00, then watch the modulator pins
    c0 = rs_cnt;
    cmd(8'h41);
    cmd(8'h00);
    cmd(8'h00);
    chk("restart_wr", c0 + 1, rs_cnt);
    chk("oe_mod", 3'h7, {O_MOD_CLK_OE, O_MODULATOR_BIT_B_OE, O_MODULATOR_BIT_A_OE});
    chk("mbits", 2'h1, {O_MODULATOR_BIT_B, O_MODULATOR_BIT_A});
    c0 = mck_cnt;
    repeat (40) @(posedge I_SYS_CLK);
    chk("mclk_rises", c0 + 10, mck_cnt);
    // Sync pin pulse: modulator clock held low, then rises
    I_SYNC <= 1'b0;
    repeat (4) @(posedge I_SYS_CLK);
    I_SYNC <= 1'b1;
    repeat (7) @(posedge I_SYS_CLK);
    @(negedge I_SYS_CLK);
    chk("mclk_sync_lo", 0, O_MOD_CLK);
    @(negedge I_SYS_CLK);
    chk("mclk_sync_hi", 1, O_MOD_CLK);
    rd_reg(5'h01, 8'h00);
    c0 = rs_cnt;
    cmd(8'h05);
    chk("restart_sync", c0 + 1, rs_cnt);
    // Standby and wake, both bit-0 values, then an undefined byte
    c0 = rs_cnt;
    for (int i = 0; i < 6; i++) begin
      cmd(op[i]);
      chk("standby", sb[i], O_STANDBY);
    end
    chk("restart_none", c0, rs_cnt);
    // Both calibrations, then read the six result bytes in one burst
    for (int i = 0; i < 2; i++) begin
      c0 = cal_cnt;
      cmd(8'h60 + 8'(i));
      chk("cal_start", c0 + 1, cal_cnt);
      chk("cal_gain", i, O_CAL_GAIN);
      @(posedge I_SYS_CLK);
      {I_CAL_DONE, I_CAL_VALUE} <= {1'b1, cv[i]};
      @(posedge I_SYS_CLK);
      I_CAL_DONE <= 1'b0;
    end
    cmd(8'h25);
    cmd(8'h05);
    for (int j = 0; j < 6; j++) begin
      host.xfer(8, 32'h0, rx);
      chk("cal_reg", (cv[j / 3] >> (8 * (j % 3))) & 24'hff, rx);
    end
    // Sinc only: half scale, no clip code; the timeout drops a cut byte
    cmd(8'h41);
    cmd(8'h00);
    cmd(8'h01);
    cmd(8'h10);
    host.xfer(3, 32'h0, rx);
    repeat (64) samp(sv[2], 1'b1, 1'b0);
    read_word(32'h3fffffff, 32);
    c0 = rs_cnt;
    cmd(8'h07);
    chk("restart_rst", c0 + 1, rs_cnt);
    chk("filt_def", 2'h2, O_FILTER_SELECT);
    axi_rd(4'h0, 32'h2, 32'h2, adc_cmd_pkg::RESP_OKAY);
    cmd(8'h11);
    rd_reg(5'h01, 8'h52);
    final_report();
  end
endmodule : adc_serial_command_readout_tb
